//--- umc_top.sv
// Design decisions made here: the Wishbone slave port and the register offsets.
`timescale 1ns/1ps
`default_nettype none

module umc_top (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic core_tx,
  output logic core_rx,
  input wire logic rx_event,
  input wire logic tx_event,
  output logic baud_tick,
  output logic tx_pin,
  input wire logic rx_pin,
  output logic ir_tx_pin,
  input wire logic ir_rx_pin,
  input wire logic cts_n,
  input wire logic dsr_n,
  input wire logic dcd_n,
  input wire logic ri_n,
  output logic rts_n,
  output logic dtr_n,
  output logic irq_o,
  output logic irq_oe
);

  // ----------------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------------
  logic [7:0] modem_control_ff;
  logic [2:0] int_enable_ff;
  logic [2:0] irq_status_ff;
  logic [3:0] msrc_ff;
  logic ack_ff;
  logic [31:0] dat_ff;

  logic [7:0] nxt_modem_control;
  logic [2:0] nxt_int_enable;
  logic [2:0] nxt_irq_status;

  umc_line_if lif();

  // ----------------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------------
  wire bus_req = wb_cyc_i & wb_stb_i;
  wire bus_start = bus_req & ~ack_ff;
  // Writes land at the edge where the master sees ack.
  wire bus_wr = bus_req & ack_ff & wb_we_i & wb_sel_i[0];
  wire sel_mc = (wb_adr_i == umc_pkg::OFS_MODEM_CONTROL);
  wire sel_ie = (wb_adr_i == umc_pkg::OFS_INT_ENABLE);
  wire sel_st = (wb_adr_i == umc_pkg::OFS_IRQ_STATUS);
  wire sel_ms = (wb_adr_i == umc_pkg::OFS_MODEM_STATE);
  wire wr_mc = bus_wr & sel_mc;
  wire wr_ie = bus_wr & sel_ie;
  wire wr_st = bus_wr & sel_st;

  wire loop_on = modem_control_ff[umc_pkg::MC_LOOP];
  wire [3:0] msrc = lif.msrc;

  wire [31:0] rd_mc = {24'h000000, modem_control_ff};
  wire [31:0] rd_ie = {29'h00000000, int_enable_ff};
  wire [31:0] rd_st = {29'h00000000, irq_status_ff};
  wire [31:0] rd_ms = {27'h0000000, loop_on, msrc};
  // Unmapped addresses are acknowledged and read as zero.
  wire [31:0] rd_mux = sel_mc ? rd_mc :
                       sel_ie ? rd_ie :
                       sel_st ? rd_st :
                       sel_ms ? rd_ms : 32'h00000000;

  // ----------------------------------------------------------------------
  // Modem change and interrupt events
  // ----------------------------------------------------------------------
  wire [3:0] ms_diff = msrc ^ msrc_ff;
  // RI reports only its trailing edge, the others any change.
  wire ri_fall = msrc_ff[umc_pkg::MS_RI] & ~msrc[umc_pkg::MS_RI];
  wire modem_evt = ms_diff[umc_pkg::MS_CTS] | ms_diff[umc_pkg::MS_DSR] |
                   ms_diff[umc_pkg::MS_DCD] | ri_fall;
  // Receiver and transmitter events are taken whatever the loop setting.
  wire [2:0] evt_set = {modem_evt, tx_event, rx_event};
  wire [2:0] evt_clr = wr_st ? wb_dat_i[2:0] : 3'h0;

  // Set wins over a clear in the same cycle.
  assign nxt_irq_status = (irq_status_ff & ~evt_clr) | evt_set;
  assign nxt_modem_control = wr_mc ? wb_dat_i[7:0] : modem_control_ff;
  assign nxt_int_enable = wr_ie ? wb_dat_i[2:0] : int_enable_ff;

  wire irq_level = |(irq_status_ff & int_enable_ff);

  // ----------------------------------------------------------------------
  // Interrupt pin drive
  // ----------------------------------------------------------------------
  wire int_drive = modem_control_ff[umc_pkg::MC_AUX_TWO];
  wire open_src = modem_control_ff[umc_pkg::MC_INT_TYPE];
  // Open-source drives only the high level; the board pull-down gives low.
  assign irq_o = open_src ? 1'b1 : irq_level;
  assign irq_oe = int_drive & (open_src ? irq_level : 1'b1);

  // ----------------------------------------------------------------------
  // Baud prescale
  // ----------------------------------------------------------------------
  logic tick_first;
  logic tick_second;

  umc_div #(.DIV(umc_pkg::DIV_FIRST)) u_div_first (
    .core_clk(core_clk),
    .reset(reset),
    .en_in(1'b1),
    .en_out(tick_first)
  );

  umc_div #(.DIV(umc_pkg::DIV_SECOND)) u_div_second (
    .core_clk(core_clk),
    .reset(reset),
    .en_in(tick_first),
    .en_out(tick_second)
  );

  assign baud_tick = modem_control_ff[umc_pkg::MC_CLK_SEL] ?
                     tick_second : tick_first;

  // ----------------------------------------------------------------------
  // Line routing
  // ----------------------------------------------------------------------
  assign lif.modem_control = modem_control_ff;
  assign lif.core_tx = core_tx;
  assign core_rx = lif.core_rx;

  umc_line u_line (
    .core_clk(core_clk),
    .reset(reset),
    .lif(lif.line),
    .tx_pin(tx_pin),
    .rx_pin(rx_pin),
    .ir_tx_pin(ir_tx_pin),
    .ir_rx_pin(ir_rx_pin),
    .cts_n(cts_n),
    .dsr_n(dsr_n),
    .dcd_n(dcd_n),
    .ri_n(ri_n),
    .rts_n(rts_n),
    .dtr_n(dtr_n)
  );

  // ----------------------------------------------------------------------
  // Flip-flops
  // ----------------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (reset) begin
      modem_control_ff <= umc_pkg::MODEM_CONTROL_RST;
      int_enable_ff <= umc_pkg::INT_ENABLE_RST;
      irq_status_ff <= umc_pkg::IRQ_STATUS_RST;
    end else begin
      modem_control_ff <= nxt_modem_control;
      int_enable_ff <= nxt_int_enable;
      irq_status_ff <= nxt_irq_status;
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      msrc_ff <= 4'h0;
      ack_ff <= 1'b0;
      dat_ff <= 32'h00000000;
    end else begin
      msrc_ff <= msrc;
      ack_ff <= bus_start;
      dat_ff <= bus_start ? rd_mux : dat_ff;
    end
  end

  assign wb_ack_o = ack_ff;
  assign wb_dat_o = dat_ff;

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  property p_first_period;
    @(posedge core_clk) disable iff (reset)
    tick_first |=> (!tick_first) [*8] ##1 (!tick_first) [*7] ##1 tick_first;
  endproperty
  a_first_period: assert property (p_first_period)
    else $error("bad 16 period");

  property p_clk_sel_off;
    @(posedge core_clk) disable iff (reset)
    !modem_control_ff[umc_pkg::MC_CLK_SEL] |-> baud_tick == tick_first;
  endproperty
  a_clk_sel_off: assert property (p_clk_sel_off)
    else $error("tick not /16");

  property p_clk_sel_on;
    @(posedge core_clk) disable iff (reset)
    tick_second |-> tick_first ##64 tick_second;
  endproperty
  a_clk_sel_on: assert property (p_clk_sel_on)
    else $error("bad 64 period");

  property p_plain_tx;
    @(posedge core_clk) disable iff (reset)
    !modem_control_ff[umc_pkg::MC_IR_EN] && !loop_on |=>
      tx_pin == $past(core_tx) && !ir_tx_pin;
  endproperty
  a_plain_tx: assert property (p_plain_tx)
    else $error("plain tx wrong");

  property p_ir_tx;
    @(posedge core_clk) disable iff (reset)
    modem_control_ff[umc_pkg::MC_IR_EN] && !loop_on |=>
      ir_tx_pin == !$past(core_tx) && tx_pin;
  endproperty
  a_ir_tx: assert property (p_ir_tx)
    else $error("ir tx wrong");

  property p_irq_drive;
    @(posedge core_clk) disable iff (reset)
    !int_drive |-> !irq_oe;
  endproperty
  a_irq_drive: assert property (p_irq_drive)
    else $error("irq not off");

  property p_irq_open;
    @(posedge core_clk) disable iff (reset)
    open_src && int_drive |-> irq_oe == irq_level && irq_o;
  endproperty
  a_irq_open: assert property (p_irq_open)
    else $error("open irq wrong");

  property p_loop_pins;
    @(posedge core_clk) disable iff (reset)
    loop_on |=> tx_pin && !ir_tx_pin && rts_n && dtr_n &&
      core_rx == $past(core_tx);
  endproperty
  a_loop_pins: assert property (p_loop_pins)
    else $error("loop path wrong");

  property p_rx_event;
    @(posedge core_clk) disable iff (reset)
    rx_event |=> irq_status_ff[umc_pkg::ST_RX];
  endproperty
  a_rx_event: assert property (p_rx_event)
    else $error("rx event lost");

  property p_irq_gate;
    @(posedge core_clk) disable iff (reset)
    (irq_status_ff & int_enable_ff) == 3'h0 |->
      !(irq_oe && irq_o && !open_src);
  endproperty
  a_irq_gate: assert property (p_irq_gate)
    else $error("ungated irq");

  property p_rts_pin;
    @(posedge core_clk) disable iff (reset)
    !loop_on |=> rts_n == !$past(modem_control_ff[umc_pkg::MC_RTS]);
  endproperty
  a_rts_pin: assert property (p_rts_pin)
    else $error("rts level wrong");

  property p_reset_loop;
    @(posedge core_clk) reset |=> !loop_on && modem_control_ff == 8'h00;
  endproperty
  a_reset_loop: assert property (p_reset_loop)
    else $error("reset loop set");

  property p_clk_sel_pick;
    @(posedge core_clk) disable iff (reset)
    modem_control_ff[umc_pkg::MC_CLK_SEL] |-> baud_tick == tick_second;
  endproperty
  a_clk_sel_pick: assert property (p_clk_sel_pick)
    else $error("tick not /64");

  property p_irq_active;
    @(posedge core_clk) disable iff (reset)
    int_drive && !open_src |-> irq_oe && irq_o == irq_level;
  endproperty
  a_irq_active: assert property (p_irq_active)
    else $error("active irq wrong");

  property p_modem_evt;
    @(posedge core_clk) disable iff (reset)
    modem_evt |=> irq_status_ff[umc_pkg::ST_MODEM];
  endproperty
  a_modem_evt: assert property (p_modem_evt)
    else $error("modem event lost");

  property p_tx_event;
    @(posedge core_clk) disable iff (reset)
    tx_event |=> irq_status_ff[umc_pkg::ST_TX];
  endproperty
  a_tx_event: assert property (p_tx_event)
    else $error("tx event lost");

  c_loop: cover property (@(posedge core_clk) disable iff (reset)
    !loop_on ##1 loop_on);
  c_ir_pulse: cover property (@(posedge core_clk) disable iff (reset)
    ir_tx_pin ##1 !ir_tx_pin);
  c_irq: cover property (@(posedge core_clk) disable iff (reset)
    !irq_level ##1 irq_level);
  c_div4: cover property (@(posedge core_clk) disable iff (reset)
    modem_control_ff[umc_pkg::MC_CLK_SEL] && baud_tick);

endmodule : umc_top

`default_nettype wire

//--- umc_pkg.sv
package umc_pkg;

  // ----------------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------------
  localparam logic [7:0] OFS_MODEM_CONTROL = 8'h00;
  localparam logic [7:0] OFS_INT_ENABLE = 8'h04;
  localparam logic [7:0] OFS_IRQ_STATUS = 8'h08;
  localparam logic [7:0] OFS_MODEM_STATE = 8'h0C;

  localparam logic [7:0] MODEM_CONTROL_RST = 8'h00;
  localparam logic [2:0] INT_ENABLE_RST = 3'h0;
  localparam logic [2:0] IRQ_STATUS_RST = 3'h0;

  // ----------------------------------------------------------------------
  // Modem control fields
  // ----------------------------------------------------------------------
  localparam int unsigned MC_DTR = 0;
  localparam int unsigned MC_RTS = 1;
  localparam int unsigned MC_AUX_ONE = 2;
  localparam int unsigned MC_AUX_TWO = 3;
  localparam int unsigned MC_LOOP = 4;
  localparam int unsigned MC_INT_TYPE = 5;
  localparam int unsigned MC_IR_EN = 6;
  localparam int unsigned MC_CLK_SEL = 7;

  // ----------------------------------------------------------------------
  // Modem status sources, asserted high
  // ----------------------------------------------------------------------
  localparam int unsigned MS_CTS = 0;
  localparam int unsigned MS_DSR = 1;
  localparam int unsigned MS_RI = 2;
  localparam int unsigned MS_DCD = 3;

  // ----------------------------------------------------------------------
  // Interrupt status bits
  // ----------------------------------------------------------------------
  localparam int unsigned ST_RX = 0;
  localparam int unsigned ST_TX = 1;
  localparam int unsigned ST_MODEM = 2;

  // ----------------------------------------------------------------------
  // Baud prescale
  // ----------------------------------------------------------------------
  localparam int unsigned DIV_FIRST = 16;
  localparam int unsigned DIV_SECOND = 4;

endpackage : umc_pkg

//--- umc_line_if.sv
`timescale 1ns/1ps
`default_nettype none

interface umc_line_if;
  logic [7:0] modem_control;
  logic core_tx;
  logic core_rx;
  logic [3:0] msrc;

  modport line (
    input modem_control,
    input core_tx,
    output core_rx,
    output msrc
  );

  modport ctl (
    output modem_control,
    output core_tx,
    input core_rx,
    input msrc
  );
endinterface : umc_line_if

`default_nettype wire

//--- umc_div.sv
`timescale 1ns/1ps
`default_nettype none

module umc_div #(
  parameter int unsigned DIV = 16
) (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic en_in,
  output logic en_out
);

  localparam int unsigned CW = $clog2(DIV);
  localparam logic [CW-1:0] LAST = CW'(DIV - 1);

  logic [CW-1:0] cnt_ff;
  logic [CW-1:0] nxt_cnt;
  wire at_last = (cnt_ff == LAST);

  assign nxt_cnt = at_last ? '0 : cnt_ff + 1'b1;
  assign en_out = en_in & at_last;

  always_ff @(posedge core_clk) begin
    if (reset) begin
      cnt_ff <= '0;
    end else if (en_in) begin
      cnt_ff <= nxt_cnt;
    end
  end

  property p_div_hold;
    @(posedge core_clk) disable iff (reset)
    !en_in |=> $stable(cnt_ff);
  endproperty
  a_div_hold: assert property (p_div_hold)
    else $error("divider moved idle");

endmodule : umc_div

`default_nettype wire

//--- umc_line.sv
`timescale 1ns/1ps
`default_nettype none

module umc_line (
  input wire logic core_clk,
  input wire logic reset,
  umc_line_if.line lif,
  output logic tx_pin,
  input wire logic rx_pin,
  output logic ir_tx_pin,
  input wire logic ir_rx_pin,
  input wire logic cts_n,
  input wire logic dsr_n,
  input wire logic dcd_n,
  input wire logic ri_n,
  output logic rts_n,
  output logic dtr_n
);

  wire loop_on = lif.modem_control[umc_pkg::MC_LOOP];
  wire ir_on = lif.modem_control[umc_pkg::MC_IR_EN];

  // ----------------------------------------------------------------------
  // Routing
  // ----------------------------------------------------------------------
  // External pins are cut off in loop-back; the plain pin idles high.
  wire nxt_tx = (loop_on | ir_on) ? 1'b1 : lif.core_tx;
  // Encoder: a pulse for each zero bit, low while the line is idle.
  wire nxt_ir_tx = ir_on & ~loop_on & ~lif.core_tx;
  wire pin_rx = ir_on ? ~ir_rx_pin : rx_pin;
  wire nxt_rx = loop_on ? lif.core_tx : pin_rx;
  wire nxt_rts_n = loop_on | ~lif.modem_control[umc_pkg::MC_RTS];
  wire nxt_dtr_n = loop_on | ~lif.modem_control[umc_pkg::MC_DTR];

  // Modem sources come from the low control bits in loop-back.
  wire [3:0] pin_src = {~dcd_n, ~ri_n, ~dsr_n, ~cts_n};
  wire [3:0] loop_src = {
    lif.modem_control[umc_pkg::MC_AUX_TWO],
    lif.modem_control[umc_pkg::MC_AUX_ONE],
    lif.modem_control[umc_pkg::MC_DTR],
    lif.modem_control[umc_pkg::MC_RTS]
  };
  assign lif.msrc = loop_on ? loop_src : pin_src;

  always_ff @(posedge core_clk) begin
    if (reset) begin
      tx_pin <= 1'b1;
      ir_tx_pin <= 1'b0;
      lif.core_rx <= 1'b1;
      rts_n <= 1'b1;
      dtr_n <= 1'b1;
    end else begin
      tx_pin <= nxt_tx;
      ir_tx_pin <= nxt_ir_tx;
      lif.core_rx <= nxt_rx;
      rts_n <= nxt_rts_n;
      dtr_n <= nxt_dtr_n;
    end
  end

  property p_loop_src;
    @(posedge core_clk) disable iff (reset)
    loop_on |-> lif.msrc == loop_src;
  endproperty
  a_loop_src: assert property (p_loop_src)
    else $error("loop source wrong");

endmodule : umc_line

`default_nettype wire

//--- umc_peer_model.sv
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------------------------------------
// Modem or serial peripheral on the far side of the line pins
// ----------------------------------------------------------------------
module umc_peer_model (
  input wire logic core_clk,
  input wire logic ir_mode,
  input wire logic ser_in,
  input wire logic [3:0] msig,
  input wire logic irq_o,
  input wire logic irq_oe,
  output logic rx_pin,
  output logic ir_rx_pin,
  output logic cts_n,
  output logic dsr_n,
  output logic ri_n,
  output logic dcd_n,
  output logic irq_line
);
  // An infrared pulse is high for a zero bit, and the unused line idles.
  always_ff @(posedge core_clk) begin
    rx_pin <= ir_mode ? 1'b1 : ser_in;
    ir_rx_pin <= ir_mode ? ~ser_in : 1'b0;
    cts_n <= ~msig[0];
    dsr_n <= ~msig[1];
    ri_n <= ~msig[2];
    dcd_n <= ~msig[3];
  end

  // The shared interrupt line has an external pull-down resistor.
  assign irq_line = irq_oe ? irq_o : 1'b0;
endmodule : umc_peer_model

`default_nettype wire

//--- uart_modem_control_upper_bits_tb.sv
`timescale 1ns/1ps
`default_nettype none

module uart_modem_control_upper_bits_tb;
  logic core_clk, reset, cyc, stb, we, core_tx, rx_event, tx_event;
  logic [7:0] adr;
  logic [3:0] sel, msig, sel_v;
  logic [31:0] wdat, rdat, wb_dat_o;
  logic wb_ack_o, core_rx, baud_tick, tx_pin, ir_tx_pin, rts_n, dtr_n;
  logic irq_o, irq_oe, rx_pin, ir_rx_pin, cts_n, dsr_n, ri_n, dcd_n;
  logic irq_line, ser_in, ir_mode;
  int bad_count, checks, seed, mc, mask, st, i, j, p;

  umc_top uut (.core_clk(core_clk), .reset(reset), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
    .wb_dat_i(wdat), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .core_tx(core_tx), .core_rx(core_rx), .rx_event(rx_event),
    .tx_event(tx_event), .baud_tick(baud_tick), .tx_pin(tx_pin),
    .rx_pin(rx_pin), .ir_tx_pin(ir_tx_pin), .ir_rx_pin(ir_rx_pin),
    .cts_n(cts_n), .dsr_n(dsr_n), .dcd_n(dcd_n), .ri_n(ri_n),
    .rts_n(rts_n), .dtr_n(dtr_n), .irq_o(irq_o), .irq_oe(irq_oe));

  umc_peer_model peer (.core_clk(core_clk), .ir_mode(ir_mode),
    .ser_in(ser_in), .msig(msig), .irq_o(irq_o), .irq_oe(irq_oe),
    .rx_pin(rx_pin), .ir_rx_pin(ir_rx_pin), .cts_n(cts_n),
    .dsr_n(dsr_n), .ri_n(ri_n), .dcd_n(dcd_n), .irq_line(irq_line));

  // ----------------------------------------------------------------------
  // Clock, watchdog and verdict
  // ----------------------------------------------------------------------
  initial begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end

  initial begin
    #200000;
    bad_count++;
    summarize();
  end

  task summarize;
    if (bad_count == 0 && checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : summarize

  // ----------------------------------------------------------------------
  // Bus cycles and comparisons
  // ----------------------------------------------------------------------
  task chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      bad_count++;
    end
  endtask : chk

  // The request waits for ack however long it takes; the watchdog ends a hang.
  task wb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= wr;
    adr <= a;
    sel <= sel_v;
    wdat <= d;
    do begin
      @(posedge core_clk);
    end while (wb_ack_o !== 1'b1);
    rdat = wb_dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask : wb

  task rd(input logic [7:0] a, input logic [31:0] exp);
    wb(1'b0, a, 32'h0);
    chk(rdat, exp);
  endtask : rd

  // The pin level follows the enable and the value from the model state.
  task chk_irq;
    logic lvl;
    lvl = |(st & mask & 7);
    @(negedge core_clk);
    if (!mc[3]) chk(irq_oe, 1'b0);
    else if (!mc[5]) chk({irq_oe, irq_o}, {1'b1, lvl});
    else chk({irq_oe, irq_line}, {lvl, lvl});
  endtask : chk_irq

  task tick_gap(output int g);
    int n;
    n = 0;
    @(negedge core_clk);
    while (baud_tick !== 1'b1 && n < 200) begin
      @(negedge core_clk);
      n++;
    end
    g = 0;
    do begin
      @(negedge core_clk);
      g++;
    end while (baud_tick !== 1'b1 && g < 200);
  endtask : tick_gap

  // ----------------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------------
  initial begin
    seed = 25;
    bad_count = 0;
    checks = 0;
    {reset, cyc, stb, we, adr, sel, wdat} = {4'h8, 8'h00, 4'h0, 32'h0};
    {core_tx, rx_event, tx_event, ser_in, ir_mode} = 5'b10010;
    msig = 4'h0;
    sel_v = 4'hF;
    mc = 0;
    mask = 0;
    st = 0;
    repeat (2) @(posedge core_clk);
    reset <= 1'b0;
    @(negedge core_clk);
    chk({tx_pin, ir_tx_pin, rts_n, dtr_n, irq_oe}, 5'b10110);
    rd(umc_pkg::OFS_MODEM_CONTROL, 32'h0);
    rd(umc_pkg::OFS_MODEM_STATE, 32'h0);
    // A write without its low byte lane, or to no register, changes nothing.
    sel_v = 4'hE;
    wb(1'b1, umc_pkg::OFS_MODEM_CONTROL, 32'hFF);
    sel_v = 4'hF;
    wb(1'b1, 8'h40, 32'hFF);
    rd(umc_pkg::OFS_MODEM_CONTROL, 32'h0);
    rd(8'h40, 32'h0);
    tick_gap(p);
    chk(p, 16);
    mc = 32'h80;
    wb(1'b1, umc_pkg::OFS_MODEM_CONTROL, mc);
    tick_gap(p);
    tick_gap(p);
    chk(p, 64);
    for (i = 0; i < 3; i++) begin
      ir_mode <= (i == 1);
      msig <= 4'($random(seed));
      mc = (i == 0 ? 32'h00 : i == 1 ? 32'h40 : 32'h10);
      mc = mc | ($random(seed) & 32'h0F);
      wb(1'b1, umc_pkg::OFS_MODEM_CONTROL, mc);
      rd(umc_pkg::OFS_MODEM_CONTROL, mc);
      @(negedge core_clk);
      chk({rts_n, dtr_n}, i == 2 ? 2'b11 : {!mc[1], !mc[0]});
      rd(umc_pkg::OFS_MODEM_STATE, i == 2 ?
        {1'b1, mc[3], mc[2], mc[0], mc[1]} : {1'b0, msig});
      for (j = 0; j < 6; j++) begin
        @(posedge core_clk);
        core_tx <= 1'($random(seed));
        ser_in <= 1'($random(seed));
        repeat (3) @(posedge core_clk);
        @(negedge core_clk);
        if (i == 0) chk({tx_pin, ir_tx_pin, core_rx},
          {core_tx, 1'b0, ser_in});
        if (i == 1) chk({tx_pin, ir_tx_pin, core_rx},
          {1'b1, ~core_tx, ser_in});
        if (i == 2) chk({tx_pin, core_rx}, {1'b1, core_tx});
      end
    end
    wb(1'b1, umc_pkg::OFS_IRQ_STATUS, 32'h7);
    st = 0;
    mask = 4;
    wb(1'b1, umc_pkg::OFS_INT_ENABLE, mask);
    mc = mc ^ 32'h0A;
    wb(1'b1, umc_pkg::OFS_MODEM_CONTROL, mc);
    st = 4;
    repeat (2) @(posedge core_clk);
    rd(umc_pkg::OFS_IRQ_STATUS, st);
    chk_irq();
    mask = 0;
    wb(1'b1, umc_pkg::OFS_INT_ENABLE, mask);
    chk_irq();
    mask = 3;
    wb(1'b1, umc_pkg::OFS_INT_ENABLE, mask);
    for (j = 0; j < 3; j++) begin
      mc = 32'h10 | (j == 0 ? 32'h00 : j == 1 ? 32'h08 : 32'h28);
      wb(1'b1, umc_pkg::OFS_MODEM_CONTROL, mc);
      wb(1'b1, umc_pkg::OFS_IRQ_STATUS, 32'h7);
      st = 0;
      chk_irq();
      @(posedge core_clk);
      rx_event <= (j != 1);
      tx_event <= (j != 0);
      @(posedge core_clk);
      rx_event <= 1'b0;
      tx_event <= 1'b0;
      st = {j != 0, j != 1};
      @(posedge core_clk);
      chk_irq();
      rd(umc_pkg::OFS_IRQ_STATUS, st);
      wb(1'b1, umc_pkg::OFS_IRQ_STATUS, 32'h3);
      st = 0;
      chk_irq();
    end
    mc = 0;
    wb(1'b1, umc_pkg::OFS_MODEM_CONTROL, mc);
    rd(umc_pkg::OFS_MODEM_STATE, {1'b0, msig});
    core_tx <= 1'b0;
    ser_in <= 1'b1;
    repeat (3) @(posedge core_clk);
    @(negedge core_clk);
    chk({tx_pin, core_rx, rts_n}, 3'b011);
    summarize();
  end
endmodule : uart_modem_control_upper_bits_tb

`default_nettype wire
